/* File: rtl/ssq_pkg.sv */
// Notes on behaviour
// - low battery comparator low pulls flag low
// - wall present: run from supply, open usb
// - power good low on wall or usb
// - no supply draw below supply threshold
// - usb switch needs usb, no suspend, no wall
// - current select high 500ma, default 100ma
// - suspend disables usb, low bias draw
// - peripheral rail 0.8ms after core good
// - card rail 0.5ms after core good
// - key low turns device on
// - key status output follows key
// - hold high turns on, undriven low
// - mode low forces pwm, high allows skipping
// - usb or wall power forces pwm
// - pwm forced during 262ms start delay
// - reset low until 262ms after rails good
// - rail loss pulls reset low
// - reset low at power off
// - fixed order internal, core, card, peripheral
package ssq_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // ------------------------------------------------------------
    // delays
    // ------------------------------------------------------------
    localparam int unsigned PERIPH_DELAY_US = 800;
    localparam int unsigned CARD_DELAY_US = 500;
    localparam int unsigned RESET_DELAY_MS = 262;
    localparam int unsigned PERIPH_CYCLES = PERIPH_DELAY_US * (CLK_HZ / 1000000);
    localparam int unsigned CARD_CYCLES = CARD_DELAY_US * (CLK_HZ / 1000000);
    localparam int unsigned RESET_CYCLES = RESET_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 24;
    // ------------------------------------------------------------
    // wishbone register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam int unsigned CTRL_FORCE_OFF = 0;
    typedef enum logic [2:0] {
        SSQ_OFF, SSQ_INT_UP, SSQ_CORE_UP, SSQ_RAILS_UP, SSQ_RUN
    } ssq_state_e;
endpackage

/* File: rtl/ssq_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module ssq_sequencer #(
    parameter int unsigned PERIPH_CYC = ssq_pkg::PERIPH_CYCLES,
    parameter int unsigned CARD_CYC = ssq_pkg::CARD_CYCLES,
    parameter int unsigned RESET_CYC = ssq_pkg::RESET_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic low_batt_sense_i,
    input wire logic wall_sense_i,
    input wire logic usb_above_4v_i,
    input wire logic ext_supply_in_i,
    input wire logic suspend_i,
    input wire logic usb_high_current_sel_i,
    input wire logic power_key_n_i,
    input wire logic power_hold_i,
    input wire logic mode_i,
    input wire logic internal_rail_good_i,
    input wire logic core_feedback_good_i,
    input wire logic peripheral_rail_good_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic low_batt_flag_n_oe_o,
    output logic ext_power_good_n_oe_o,
    output logic key_status_n_oe_o,
    output logic reset_n_oe_o,
    output logic ext_supply_draw_o,
    output logic usb_switch_on_o,
    output logic usb_500ma_o,
    output logic usb_suspend_o,
    output logic internal_rail_en_o,
    output logic core_rail_en_o,
    output logic peripheral_rail_en_o,
    output logic card_rail_en_o,
    output logic force_pwm_o
);
    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    // open-drain enables are low while the pin is pulled down
    wire usb_ok = usb_above_4v_i && !suspend_i;
    wire src_ok = ext_supply_in_i;
    wire on_request = !power_key_n_i || power_hold_i;
    wire next_usb_switch = usb_ok && !wall_sense_i;
    wire ext_powered = wall_sense_i || next_usb_switch;
    localparam int CNT_W_L = ssq_pkg::CNT_W;
    logic [31:0] ctrl;
    logic [CNT_W_L-1:0] cnt;
    ssq_pkg::ssq_state_e state;
    logic reset_done;
    wire force_off = ctrl[ssq_pkg::CTRL_FORCE_OFF];
    wire want_on = on_request && !force_off;
    wire rails_good = internal_rail_good_i && core_feedback_good_i;
    wire per_due = cnt >= CNT_W_L'(PERIPH_CYC);
    wire card_due = cnt >= CNT_W_L'(CARD_CYC);
    wire rst_due = cnt >= CNT_W_L'(RESET_CYC);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_batt_flag_n_oe_o <= 1'b1;
        end else begin
            low_batt_flag_n_oe_o <= low_batt_sense_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_power_good_n_oe_o <= 1'b1;
        end else begin
            ext_power_good_n_oe_o <= !(wall_sense_i || usb_ok);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_status_n_oe_o <= 1'b1;
        end else begin
            key_status_n_oe_o <= power_key_n_i;
        end
    end

    // no draw from the supply pin until its detector says it is up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_supply_draw_o <= 1'b0;
        end else begin
            ext_supply_draw_o <= src_ok && ext_powered;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_switch_on_o <= 1'b0;
        end else begin
            usb_switch_on_o <= next_usb_switch;
        end
    end

    // low current is the safe default until usb is usable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_500ma_o <= 1'b0;
        end else begin
            usb_500ma_o <= usb_high_current_sel_i && usb_ok;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_suspend_o <= 1'b0;
        end else begin
            usb_suspend_o <= suspend_i;
        end
    end

    // ------------------------------------------------------------
    // power sequencing
    // ------------------------------------------------------------
    // core loss pulls reset low and reruns the reset delay; rails stay enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ssq_pkg::SSQ_OFF;
            cnt <= '0;
            internal_rail_en_o <= 1'b0;
            core_rail_en_o <= 1'b0;
            peripheral_rail_en_o <= 1'b0;
            card_rail_en_o <= 1'b0;
            reset_n_oe_o <= 1'b0;
            reset_done <= 1'b0;
            force_pwm_o <= 1'b1;
        end else begin
            force_pwm_o <= !mode_i || ext_powered || !reset_done;
            case (state)
                ssq_pkg::SSQ_OFF: begin
                    reset_n_oe_o <= 1'b0;
                    reset_done <= 1'b0;
                    cnt <= '0;
                    internal_rail_en_o <= 1'b0;
                    core_rail_en_o <= 1'b0;
                    peripheral_rail_en_o <= 1'b0;
                    card_rail_en_o <= 1'b0;
                    if (want_on && (src_ok || !ext_powered)) begin
                        internal_rail_en_o <= 1'b1;
                        state <= ssq_pkg::SSQ_INT_UP;
                    end
                end
                ssq_pkg::SSQ_INT_UP: begin
                    if (!want_on) begin
                        state <= ssq_pkg::SSQ_OFF;
                    end else if (internal_rail_good_i) begin
                        core_rail_en_o <= 1'b1;
                        state <= ssq_pkg::SSQ_CORE_UP;
                    end
                end
                ssq_pkg::SSQ_CORE_UP: begin
                    if (!want_on) begin
                        state <= ssq_pkg::SSQ_OFF;
                    end else if (core_feedback_good_i) begin
                        cnt <= cnt + CNT_W_L'(1);
                        if (card_due) begin
                            card_rail_en_o <= 1'b1;
                        end
                        if (per_due) begin
                            peripheral_rail_en_o <= 1'b1;
                            cnt <= '0;
                            state <= ssq_pkg::SSQ_RAILS_UP;
                        end
                    end else begin
                        cnt <= '0;
                    end
                end
                ssq_pkg::SSQ_RAILS_UP, ssq_pkg::SSQ_RUN: begin
                    card_rail_en_o <= 1'b1;
                    if (!want_on) begin
                        state <= ssq_pkg::SSQ_OFF;
                    end else if (!(rails_good && peripheral_rail_good_i)) begin
                        reset_n_oe_o <= 1'b0;
                        cnt <= '0;
                        state <= ssq_pkg::SSQ_RAILS_UP;
                    end else if (state == ssq_pkg::SSQ_RAILS_UP) begin
                        cnt <= cnt + CNT_W_L'(1);
                        if (rst_due) begin
                            reset_n_oe_o <= 1'b1;
                            reset_done <= 1'b1;
                            state <= ssq_pkg::SSQ_RUN;
                        end
                    end
                end
                default: state <= ssq_pkg::SSQ_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire hit_ctrl = wb_adr_i == ssq_pkg::ADDR_CTRL;
    wire hit_stat = wb_adr_i == ssq_pkg::ADDR_STATUS;
    wire [31:0] status_word = {22'h000000, reset_done, state, usb_switch_on_o, ext_supply_draw_o,
                               card_rail_en_o, peripheral_rail_en_o, core_rail_en_o, internal_rail_en_o};
    wire [31:0] rd_word = hit_stat ? status_word : (hit_ctrl ? ctrl : 32'h00000000);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= ssq_pkg::CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= rd_word;
            if (wb_req && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
                ctrl[7:0] <= wb_dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_lowbatt;
        @(posedge clk_i) disable iff (rst_i) 1 |=> low_batt_flag_n_oe_o == $past(low_batt_sense_i);
    endproperty
    a_lowbatt: assert property (p_lowbatt) else $error("low battery flag wrong");
    property p_usbsw;
        @(posedge clk_i) disable iff (rst_i) (wall_sense_i || suspend_i) |=> !usb_switch_on_o;
    endproperty
    a_usbsw: assert property (p_usbsw) else $error("usb switch closed");
    property p_pg;
        @(posedge clk_i) disable iff (rst_i) wall_sense_i |=> !ext_power_good_n_oe_o;
    endproperty
    a_pg: assert property (p_pg) else $error("power good not low");
    property p_key;
        @(posedge clk_i) disable iff (rst_i) 1 |=> key_status_n_oe_o == $past(power_key_n_i);
    endproperty
    a_key: assert property (p_key) else $error("key status wrong");
    property p_pwm;
        @(posedge clk_i) disable iff (rst_i) (!mode_i || wall_sense_i) |=> force_pwm_o;
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm not forced");
    property p_rst_run;
        @(posedge clk_i) disable iff (rst_i) reset_n_oe_o |-> reset_done;
    endproperty
    a_rst_run: assert property (p_rst_run) else $error("reset released early");
    property p_order;
        @(posedge clk_i) disable iff (rst_i) peripheral_rail_en_o |-> core_rail_en_o && internal_rail_en_o;
    endproperty
    a_order: assert property (p_order) else $error("rail order broken");
    property p_off;
        @(posedge clk_i) disable iff (rst_i) state == ssq_pkg::SSQ_OFF |=> !reset_n_oe_o;
    endproperty
    a_off: assert property (p_off) else $error("reset high while off");

    sequence s_usb_present;
        usb_above_4v_i && !suspend_i;
    endsequence

    sequence s_start_req;
        state == ssq_pkg::SSQ_OFF && want_on && (src_ok || !ext_powered);
    endsequence

    sequence s_stop_req;
        state != ssq_pkg::SSQ_OFF && !want_on;
    endsequence

    property p_pg_usb;
        @(posedge clk_i) disable iff (rst_i) s_usb_present |=> !ext_power_good_n_oe_o;
    endproperty
    a_pg_usb: assert property (p_pg_usb) else $error("power good not low on usb");

    property p_pg_rel;
        @(posedge clk_i) disable iff (rst_i) (!wall_sense_i && !(usb_above_4v_i && !suspend_i)) |=> ext_power_good_n_oe_o;
    endproperty
    a_pg_rel: assert property (p_pg_rel) else $error("power good not released");

    property p_usb_on;
        @(posedge clk_i) disable iff (rst_i) (usb_above_4v_i && !suspend_i && !wall_sense_i) |=> usb_switch_on_o;
    endproperty
    a_usb_on: assert property (p_usb_on) else $error("usb switch not closed");

    property p_draw_gate;
        @(posedge clk_i) disable iff (rst_i) !ext_supply_in_i |=> !ext_supply_draw_o;
    endproperty
    a_draw_gate: assert property (p_draw_gate) else $error("supply drawn below threshold");

    property p_wall_draw;
        @(posedge clk_i) disable iff (rst_i) (wall_sense_i && ext_supply_in_i) |=> ext_supply_draw_o;
    endproperty
    a_wall_draw: assert property (p_wall_draw) else $error("wall power not used");

    property p_hc;
        @(posedge clk_i) disable iff (rst_i) (usb_high_current_sel_i && usb_above_4v_i && !suspend_i) |=> usb_500ma_o;
    endproperty
    a_hc: assert property (p_hc) else $error("high current not selected");

    property p_lc;
        @(posedge clk_i) disable iff (rst_i) !usb_high_current_sel_i |=> !usb_500ma_o;
    endproperty
    a_lc: assert property (p_lc) else $error("low current not selected");

    property p_susp;
        @(posedge clk_i) disable iff (rst_i) suspend_i |=> usb_suspend_o && !usb_500ma_o;
    endproperty
    a_susp: assert property (p_susp) else $error("usb active in suspend");

    property p_mode_free;
        @(posedge clk_i) disable iff (rst_i)
            (mode_i && !wall_sense_i && !(usb_above_4v_i && !suspend_i) && reset_done) |=> !force_pwm_o;
    endproperty
    a_mode_free: assert property (p_mode_free) else $error("light load mode blocked");

    property p_usb_pwm;
        @(posedge clk_i) disable iff (rst_i) s_usb_present |=> force_pwm_o;
    endproperty
    a_usb_pwm: assert property (p_usb_pwm) else $error("pwm not forced on usb");

    property p_start_pwm;
        @(posedge clk_i) disable iff (rst_i) !reset_done |=> force_pwm_o;
    endproperty
    a_start_pwm: assert property (p_start_pwm) else $error("pwm not forced at start");

    property p_card_delay;
        @(posedge clk_i) disable iff (rst_i)
            ($rose(card_rail_en_o) && $past(state) == ssq_pkg::SSQ_CORE_UP) |-> $past(cnt) >= CNT_W_L'(CARD_CYC);
    endproperty
    a_card_delay: assert property (p_card_delay) else $error("card rail early");

    property p_per_delay;
        @(posedge clk_i) disable iff (rst_i) $rose(peripheral_rail_en_o) |-> $past(cnt) >= CNT_W_L'(PERIPH_CYC);
    endproperty
    a_per_delay: assert property (p_per_delay) else $error("peripheral rail early");

    property p_rst_delay;
        @(posedge clk_i) disable iff (rst_i) $rose(reset_n_oe_o) |-> $past(cnt) >= CNT_W_L'(RESET_CYC);
    endproperty
    a_rst_delay: assert property (p_rst_delay) else $error("reset released before delay");

    property p_rst_loss;
        @(posedge clk_i) disable iff (rst_i)
            (state == ssq_pkg::SSQ_RUN && want_on && !(rails_good && peripheral_rail_good_i)) |=> !reset_n_oe_o;
    endproperty
    a_rst_loss: assert property (p_rst_loss) else $error("reset not pulled on rail loss");

    property p_core_order;
        @(posedge clk_i) disable iff (rst_i) core_rail_en_o |-> internal_rail_en_o;
    endproperty
    a_core_order: assert property (p_core_order) else $error("core before internal");

    property p_card_order;
        @(posedge clk_i) disable iff (rst_i) card_rail_en_o |-> core_rail_en_o;
    endproperty
    a_card_order: assert property (p_card_order) else $error("card before core");

    property p_on;
        @(posedge clk_i) disable iff (rst_i) s_start_req |=> internal_rail_en_o;
    endproperty
    a_on: assert property (p_on) else $error("no start on request");

    property p_drop;
        @(posedge clk_i) disable iff (rst_i) s_stop_req |=> state == ssq_pkg::SSQ_OFF;
    endproperty
    a_drop: assert property (p_drop) else $error("no shutdown on release");

    property p_off_rails;
        @(posedge clk_i) disable iff (rst_i) (state == ssq_pkg::SSQ_OFF && !want_on)
            |=> !internal_rail_en_o && !core_rail_en_o && !peripheral_rail_en_o && !card_rail_en_o;
    endproperty
    a_off_rails: assert property (p_off_rails) else $error("rail on while off");

    property p_no_src;
        @(posedge clk_i) disable iff (rst_i) (state == ssq_pkg::SSQ_OFF && ext_powered && !src_ok) |=> !internal_rail_en_o;
    endproperty
    a_no_src: assert property (p_no_src) else $error("start without supply");

    // single-cycle ack keeps back-to-back requests apart
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_ack_req;
        @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("request not acknowledged");
endmodule
`default_nettype wire

/* File: verif/ssq_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ssq_host_model (
    input wire logic clk_i,
    input wire logic on_req_i,
    input wire logic reset_n_i,
    output logic power_key_n_o = 1'b1,
    output logic power_hold_o = 1'b0
);
    // ----
    // processor side of the on/off handshake
    // ----
    // key stays pressed until the processor runs and owns the hold line
    always @(posedge clk_i) begin
        if (!on_req_i) begin
            power_key_n_o <= 1'b1;
            power_hold_o <= 1'b0;
        end else if (reset_n_i) begin
            power_hold_o <= 1'b1;
            power_key_n_o <= power_hold_o;
        end else begin
            power_key_n_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int P = 8;
    localparam int C = 5;
    localparam int R = 20;
    logic clk = 1'b0, rst = 1'b1, lbs = 1'b1, wall = 1'b0, usb = 1'b0, ext = 1'b0, susp = 1'b0, hc = 1'b0;
    logic mode = 1'b0, flt = 1'b0, on_req = 1'b0, ig = 1'b0, cg = 1'b0, pg = 1'b0, we = 1'b0, cyc = 1'b0;
    logic stb = 1'b0, key_n, hold, ack, lbf, epg, ksn, rsn, draw, usw, u500, usus, ien, cen, pen, den, fpwm;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rd, q;
    int n_fail = 0, n_tests = 0;
    always #20 clk = ~clk;
    // rails report good one cycle after enable; flt knocks the core out
    always @(posedge clk) begin
        ig <= ien;
        cg <= cen & ~flt;
        pg <= pen;
    end
    ssq_host_model i_ssq_host_model (.clk_i(clk), .on_req_i(on_req), .reset_n_i(rsn),
        .power_key_n_o(key_n), .power_hold_o(hold));
    ssq_sequencer #(.PERIPH_CYC(P), .CARD_CYC(C), .RESET_CYC(R)) i_ssq_sequencer (
        .clk_i(clk), .rst_i(rst), .low_batt_sense_i(lbs), .wall_sense_i(wall), .usb_above_4v_i(usb),
        .ext_supply_in_i(ext), .suspend_i(susp), .usb_high_current_sel_i(hc), .power_key_n_i(key_n),
        .power_hold_i(hold), .mode_i(mode), .internal_rail_good_i(ig), .core_feedback_good_i(cg),
        .peripheral_rail_good_i(pg), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack), .low_batt_flag_n_oe_o(lbf),
        .ext_power_good_n_oe_o(epg), .key_status_n_oe_o(ksn), .reset_n_oe_o(rsn),
        .ext_supply_draw_o(draw), .usb_switch_on_o(usw), .usb_500ma_o(u500), .usb_suspend_o(usus),
        .internal_rail_en_o(ien), .core_rail_en_o(cen), .peripheral_rail_en_o(pen),
        .card_rail_en_o(den), .force_pwm_o(fpwm));
    // ----
    // helpers
    // ----
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask
    task close_out;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task t_up;
        int n, kc, kp, kr;
        kc = 0;
        kp = 0;
        kr = 0;
        mode <= 1'b1;
        on_req <= 1'b1;
        repeat (3) @(posedge clk);
        chk(ksn, 1'b0);
        chk(ien, 1'b1);
        for (n = 0; n < 50 && cg !== 1'b1; n++) @(posedge clk);
        chk({ien, pen, den}, 3'b100);
        for (n = 1; n < 80; n++) begin
            @(posedge clk);
            if (den && kc == 0) kc = n;
            if (pen && kp == 0) kp = n;
            if (rsn && kr == 0) kr = n;
            if (kr == 0) chk(fpwm, 1'b1);
        end
        chk(kc >= C && kc <= C + 3, 1'b1);
        chk(kp >= P && kp <= P + 3, 1'b1);
        chk(kr >= P + R && kr <= P + R + 6, 1'b1);
        chk({ksn, ien}, 2'b11);
        chk(fpwm, 1'b0);
        mode <= 1'b0;
        repeat (3) @(posedge clk);
        chk(fpwm, 1'b1);
        mode <= 1'b1;
        usb <= 1'b1;
        repeat (3) @(posedge clk);
        chk(fpwm, 1'b1);
    endtask
    task t_pins;
        logic [5:0] v;
        for (int i = 0; i < 64; i++) begin
            v = i[5:0];
            {lbs, wall, usb, ext, susp, hc} <= v;
            repeat (3) @(posedge clk);
            chk({lbf, epg, usw, u500, usus}, {v[5], ~(v[4] | v[3] & ~v[1]), v[3] & ~v[1] & ~v[4], v[0] & v[3] & ~v[1], v[1]});
            if (!v[2]) chk(draw, 1'b0);
            if (v[4] && v[2]) chk(draw, 1'b1);
        end
        {lbs, wall, usb, ext, susp, hc} <= 6'h20;
    endtask
    task t_loss;
        int n;
        flt <= 1'b1;
        repeat (3) @(posedge clk);
        chk(rsn, 1'b0);
        flt <= 1'b0;
        for (n = 0; n < 100 && rsn !== 1'b1; n++) @(posedge clk);
        chk(rsn, 1'b1);
    endtask
    task t_regs;
        wb(1'b0, 4'h0, 32'h0);
        chk({q[9], q[3:0]}, 5'h1f);
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 4'hc, 32'hffffffff);
        wb(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 4'h4, 32'hffffff01);
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h1);
        repeat (3) @(posedge clk);
        chk({rsn, cen}, 2'b00);
        on_req <= 1'b0;
        repeat (3) @(posedge clk);
        wb(1'b1, 4'h4, 32'h0);
        repeat (10) @(posedge clk);
        chk({rsn, ien, cen, pen, den}, 5'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_up;
        t_pins;
        t_loss;
        t_regs;
        close_out;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        close_out;
    end
endmodule
`default_nettype wire
